/* flipc_params.svh */
// Constants of the four-level interrupt priority controller.
// Assumes sources are numbered by natural order, index 0 ranked highest.
// Function
// - Per-source enable gates each request
// - Global enable low blocks every source request; wake is not gated
// - Masked requests stay pending until enabled
// - Any set flag raises its interrupt
// - Software writes flags: one sets, zero clears
// - Two bits give levels zero to three
// - Preempt only by strictly higher level
// - Return resumes interrupted lower level service
// - Highest level wins, ties by natural order
// - Fixed natural order of eighteen sources
// - Fixed vector address per source
// - Only listed sources wake from power-down
// - External flag: edge autoclears, level is the inverted pin
// - Timers 0,1,3 autoclear; timer 2 not
// - Level pin channel flag mirrors channel state
`ifndef FLIPC_PARAMS_SVH
`define FLIPC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define FLIPC_NSRC 18
`define FLIPC_NPIN 8
`define FLIPC_IDXW 5

// ----------------------------------------------------------------------------
// Source indices in natural order
// ----------------------------------------------------------------------------
`define FLIPC_SRC_EXT0  5'h00
`define FLIPC_SRC_BOD   5'h01
`define FLIPC_SRC_WDT   5'h02
`define FLIPC_SRC_TMR0  5'h03
`define FLIPC_SRC_I2C   5'h04
`define FLIPC_SRC_ADC   5'h05
`define FLIPC_SRC_EXT1  5'h06
`define FLIPC_SRC_PIN   5'h07
`define FLIPC_SRC_TMR1  5'h08
`define FLIPC_SRC_SER0  5'h09
`define FLIPC_SRC_FB    5'h0a
`define FLIPC_SRC_SPI   5'h0b
`define FLIPC_SRC_TMR2  5'h0c
`define FLIPC_SRC_CAP   5'h0d
`define FLIPC_SRC_PWM   5'h0e
`define FLIPC_SRC_SER1  5'h0f
`define FLIPC_SRC_TMR3  5'h10
`define FLIPC_SRC_WKT   5'h11

// ----------------------------------------------------------------------------
// Vector addresses
// ----------------------------------------------------------------------------
`define FLIPC_VEC_RESET 16'h0000
`define FLIPC_VEC_EXT0  16'h0003
`define FLIPC_VEC_TMR0  16'h000b
`define FLIPC_VEC_EXT1  16'h0013
`define FLIPC_VEC_TMR1  16'h001b
`define FLIPC_VEC_SER0  16'h0023
`define FLIPC_VEC_TMR2  16'h002b
`define FLIPC_VEC_I2C   16'h0033
`define FLIPC_VEC_PIN   16'h003b
`define FLIPC_VEC_BOD   16'h0043
`define FLIPC_VEC_SPI   16'h004b
`define FLIPC_VEC_WDT   16'h0053
`define FLIPC_VEC_ADC   16'h005b
`define FLIPC_VEC_CAP   16'h0063
`define FLIPC_VEC_PWM   16'h006b
`define FLIPC_VEC_FB    16'h0073
`define FLIPC_VEC_SER1  16'h007b
`define FLIPC_VEC_TMR3  16'h0083
`define FLIPC_VEC_WKT   16'h008b

// ----------------------------------------------------------------------------
// Source masks and reset values
// ----------------------------------------------------------------------------
`define FLIPC_WAKE_MASK    18'h200c7
`define FLIPC_AUTOCLR_MASK 18'h10108
`define FLIPC_FLAG_RST     18'h00000
`define FLIPC_SVC_RST      4'h0

`endif

/* flipc_pkg.sv */
// Types shared by the interrupt priority controller modules.
// Assumes flipc_params.svh is on the include path.
`include "flipc_params.svh"

package flipc_pkg;

  typedef logic [1:0]              flipc_lvl_t;
  typedef logic [`FLIPC_IDXW-1:0]  flipc_idx_t;
  typedef logic [`FLIPC_NSRC-1:0]  flipc_vec_t;

  typedef struct packed {
    flipc_vec_t               flag_r;
    logic [`FLIPC_NPIN-1:0]   pin_flag_r;
    logic [1:0]               ext_prev_r;
    logic [3:0]               svc_r;
    logic                     req_r;
    flipc_idx_t               src_r;
    flipc_lvl_t               lvl_r;
    logic [15:0]              vec_r;
    logic                     wake_r;
  } flipc_state_s;

  // Highest level currently marked in service.
  function automatic flipc_lvl_t flipc_top_level(input logic [3:0] svc);
    flipc_lvl_t l;
    l = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (svc[i]) begin
        l = flipc_lvl_t'(i);
      end
    end
    return l;
  endfunction

endpackage

/* flipc_arbiter.sv */
// Combinational winner pick among pending, enabled requests.
// Assumes index 0 is the highest natural rank.
`timescale 1ns/1ps
`include "flipc_params.svh"

module flipc_arbiter
  import flipc_pkg::*;
#(
  parameter int N  = `FLIPC_NSRC,
  parameter int IW = `FLIPC_IDXW
) (
  input  wire logic [N-1:0]  req_in,      // Eligible requests
  input  wire logic [N-1:0]  prio_hi_in,  // Level high bits
  input  wire logic [N-1:0]  prio_lo_in,  // Level low bits
  output logic               found_out,   // Any request present
  output logic [IW-1:0]      idx_out,     // Winning source index
  output flipc_lvl_t         lvl_out      // Winning level
);

  // --------------------------------------------------------------------------
  // Priority search
  // --------------------------------------------------------------------------
  // Scanning from the lowest rank up with >= lets a higher natural rank
  // replace an equal-level candidate, so ties settle by natural order.
  always_comb begin
    flipc_lvl_t l;
    l         = 2'h0;
    found_out = 1'b0;
    idx_out   = '0;
    lvl_out   = 2'h0;
    for (int i = N - 1; i >= 0; i--) begin
      l = {prio_hi_in[i], prio_lo_in[i]};
      if (req_in[i] && (!found_out || l >= lvl_out)) begin
        found_out = 1'b1;
        idx_out   = IW'(i);
        lvl_out   = l;
      end
    end
  end

endmodule

/* flipc_ctrl.sv */
// Four-level interrupt priority controller: flags, enables, arbitration,
// service-level tracking, vector and power-down wake request.
// Assumes a core that samples the registered request at instruction
// boundaries, pulses take_in when it vectors and reti_in on return.
`timescale 1ns/1ps
`include "flipc_params.svh"

module flipc_ctrl
  import flipc_pkg::*;
#(
  parameter int NPIN = `FLIPC_NPIN
) (
  input  wire logic                  clk_in,              // System clock
  input  wire logic                  rst_in,              // Sync reset, high
  input  wire logic                  global_irq_enable_in, // Global enable
  input  wire logic [17:0]           enable_in,           // Per-source enable
  input  wire logic [17:0]           priority_high_bits_in, // Level high bit
  input  wire logic [17:0]           priority_low_bits_in,  // Level low bit
  input  wire logic [17:0]           hw_set_in,           // Flag set pulses
  input  wire logic                  sw_wr_in,            // Flag write strobe
  input  wire flipc_idx_t            sw_idx_in,           // Flag write index
  input  wire logic                  sw_data_in,          // Flag write value
  input  wire logic                  ext0_pin_in,         // External 0 pin
  input  wire logic                  ext1_pin_in,         // External 1 pin
  input  wire logic [1:0]            ext_edge_mode_in,    // 1 edge, 0 level
  input  wire logic [NPIN-1:0]       pin_level_mode_in,   // 1 level channel
  input  wire logic [NPIN-1:0]       pin_state_in,        // Level chan state
  input  wire logic [NPIN-1:0]       pin_set_in,          // Edge chan pulses
  input  wire logic                  pin_wr_in,           // Pin flag write
  input  wire logic [NPIN-1:0]       pin_wr_data_in,      // Pin flag values
  input  wire logic [1:0]            twowire_flags_in,    // Status, time-out
  input  wire logic [1:0]            serial0_flags_in,    // Receive, transmit
  input  wire logic [2:0]            serial_periph_flags_in, // Three flags
  input  wire logic [2:0]            capture_flags_in,    // Three channels
  input  wire logic [1:0]            serial1_flags_in,    // Receive, transmit
  input  wire logic                  take_in,             // Core vectors now
  input  wire logic                  reti_in,             // Handler returned
  output logic                       irq_req_out,         // Request to core
  output logic [15:0]                irq_vector_out,      // Vector address
  output flipc_idx_t                 irq_source_out,      // Winning source
  output flipc_lvl_t                 irq_level_out,       // Winning level
  output logic                       wake_out,            // Power-down wake
  output logic [17:0]                flags_out,           // Stored flags
  output logic [NPIN-1:0]            pin_flags_out,       // Pin chan flags
  output logic [3:0]                 svc_level_out        // Levels in service
);

  // --------------------------------------------------------------------------
  // Vector lookup
  // --------------------------------------------------------------------------
  function automatic logic [15:0] vec_of(input flipc_idx_t idx);
    logic [15:0] v;
    v = `FLIPC_VEC_RESET;
    case (idx)
      `FLIPC_SRC_EXT0: v = `FLIPC_VEC_EXT0;
      `FLIPC_SRC_BOD:  v = `FLIPC_VEC_BOD;
      `FLIPC_SRC_WDT:  v = `FLIPC_VEC_WDT;
      `FLIPC_SRC_TMR0: v = `FLIPC_VEC_TMR0;
      `FLIPC_SRC_I2C:  v = `FLIPC_VEC_I2C;
      `FLIPC_SRC_ADC:  v = `FLIPC_VEC_ADC;
      `FLIPC_SRC_EXT1: v = `FLIPC_VEC_EXT1;
      `FLIPC_SRC_PIN:  v = `FLIPC_VEC_PIN;
      `FLIPC_SRC_TMR1: v = `FLIPC_VEC_TMR1;
      `FLIPC_SRC_SER0: v = `FLIPC_VEC_SER0;
      `FLIPC_SRC_FB:   v = `FLIPC_VEC_FB;
      `FLIPC_SRC_SPI:  v = `FLIPC_VEC_SPI;
      `FLIPC_SRC_TMR2: v = `FLIPC_VEC_TMR2;
      `FLIPC_SRC_CAP:  v = `FLIPC_VEC_CAP;
      `FLIPC_SRC_PWM:  v = `FLIPC_VEC_PWM;
      `FLIPC_SRC_SER1: v = `FLIPC_VEC_SER1;
      `FLIPC_SRC_TMR3: v = `FLIPC_VEC_TMR3;
      `FLIPC_SRC_WKT:  v = `FLIPC_VEC_WKT;
      default:         v = `FLIPC_VEC_RESET;
    endcase
    return v;
  endfunction

  // --------------------------------------------------------------------------
  // State and request gathering
  // --------------------------------------------------------------------------
  flipc_state_s s_r;
  flipc_state_s s_nxt;
  flipc_vec_t   req_c;
  flipc_vec_t   elig_c;
  logic         found_c;
  flipc_idx_t   win_idx_c;
  flipc_lvl_t   win_lvl_c;
  logic         take_c;
  logic         allowed_c;

  // Sources whose flag is cleared by vectoring, as an indexable constant.
  localparam flipc_vec_t AUTOCLR_MASK = `FLIPC_AUTOCLR_MASK;

  // A take while nothing is presented is ignored so a stray strobe cannot
  // mark a level in service.
  assign take_c = take_in && s_r.req_r;

  // Stored flags stay set while masked, so they are served later.
  always_comb begin
    req_c = s_r.flag_r;
    req_c[`FLIPC_SRC_I2C]  = s_r.flag_r[`FLIPC_SRC_I2C] |
                             (|twowire_flags_in);
    req_c[`FLIPC_SRC_SER0] = s_r.flag_r[`FLIPC_SRC_SER0] |
                             (|serial0_flags_in);
    req_c[`FLIPC_SRC_SPI]  = s_r.flag_r[`FLIPC_SRC_SPI] |
                             (|serial_periph_flags_in);
    req_c[`FLIPC_SRC_CAP]  = s_r.flag_r[`FLIPC_SRC_CAP] |
                             (|capture_flags_in);
    req_c[`FLIPC_SRC_SER1] = s_r.flag_r[`FLIPC_SRC_SER1] |
                             (|serial1_flags_in);
    req_c[`FLIPC_SRC_PIN]  = s_r.flag_r[`FLIPC_SRC_PIN] |
                             (|s_r.pin_flag_r);
  end

  assign elig_c = req_c & enable_in &
                  {`FLIPC_NSRC{global_irq_enable_in}};

  flipc_arbiter #(
    .N  (`FLIPC_NSRC),
    .IW (`FLIPC_IDXW)
  ) u_arb (
    .req_in     (elig_c),
    .prio_hi_in (priority_high_bits_in),
    .prio_lo_in (priority_low_bits_in),
    .found_out  (found_c),
    .idx_out    (win_idx_c),
    .lvl_out    (win_lvl_c)
  );

  // Same or lower level waits while anything is in service.
  assign allowed_c = found_c &&
                     (s_r.svc_r == `FLIPC_SVC_RST ||
                      win_lvl_c > flipc_top_level(s_r.svc_r));

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic       set_b;
    logic       clr_b;
    flipc_idx_t ei;
    logic       pin_b;
    logic       edge_b;
    set_b  = 1'b0;
    clr_b  = 1'b0;
    ei     = `FLIPC_SRC_EXT0;
    pin_b  = 1'b0;
    edge_b = 1'b0;
    s_nxt  = s_r;

    // Set wins over clear for every stored flag except a level-mode external flag, which follows its pin.
    for (int i = 0; i < `FLIPC_NSRC; i++) begin
      set_b = hw_set_in[i] ||
              (sw_wr_in && sw_idx_in == flipc_idx_t'(i) && sw_data_in);
      clr_b = (sw_wr_in && sw_idx_in == flipc_idx_t'(i) && !sw_data_in) ||
              (take_c && s_r.src_r == flipc_idx_t'(i) &&
               AUTOCLR_MASK[i]);
      if (set_b) begin
        s_nxt.flag_r[i] = 1'b1;
      end else if (clr_b) begin
        s_nxt.flag_r[i] = 1'b0;
      end
    end

    // External pins: falling edge sets, entry clears; level flag is the inverted pin.
    for (int e = 0; e < 2; e++) begin
      ei     = (e == 0) ? `FLIPC_SRC_EXT0 : `FLIPC_SRC_EXT1;
      pin_b  = (e == 0) ? ext0_pin_in : ext1_pin_in;
      edge_b = s_r.ext_prev_r[e] && !pin_b;
      s_nxt.ext_prev_r[e] = pin_b;
      if (!ext_edge_mode_in[e]) begin
        s_nxt.flag_r[ei] = !pin_b;
      end else if (edge_b || hw_set_in[ei] ||
                   (sw_wr_in && sw_idx_in == ei && sw_data_in)) begin
        s_nxt.flag_r[ei] = 1'b1;
      end else if (take_c && s_r.src_r == ei) begin
        s_nxt.flag_r[ei] = 1'b0;
      end
    end

    // Pin channels; vectoring leaves these flags to software.
    for (int c = 0; c < NPIN; c++) begin
      if (pin_level_mode_in[c]) begin
        s_nxt.pin_flag_r[c] = pin_state_in[c];
      end else if (pin_set_in[c]) begin
        s_nxt.pin_flag_r[c] = 1'b1;
      end else if (pin_wr_in) begin
        s_nxt.pin_flag_r[c] = pin_wr_data_in[c];
      end
    end

    // Service levels: a return pops the top level, a take pushes one.
    if (reti_in) begin
      s_nxt.svc_r[flipc_top_level(s_r.svc_r)] = 1'b0;
    end
    if (take_c) begin
      s_nxt.svc_r[s_r.lvl_r] = 1'b1;
    end

    // Request is dropped for a cycle on take or return, so the core never
    // sees a stale winner computed before the service levels moved.
    s_nxt.req_r  = allowed_c && !take_c && !reti_in;
    s_nxt.src_r  = win_idx_c;
    s_nxt.lvl_r  = win_lvl_c;
    s_nxt.vec_r  = vec_of(win_idx_c);
    s_nxt.wake_r = |(req_c & enable_in & `FLIPC_WAKE_MASK);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign irq_req_out    = s_r.req_r;
  assign irq_vector_out = s_r.vec_r;
  assign irq_source_out = s_r.src_r;
  assign irq_level_out  = s_r.lvl_r;
  assign wake_out       = s_r.wake_r;
  assign flags_out      = s_r.flag_r;
  assign pin_flags_out  = s_r.pin_flag_r;
  assign svc_level_out  = s_r.svc_r;

endmodule

/* flipc_core_model.sv */
// Behavioural core on the far side of the interrupt controller.
// Assumes the controller registers its request on the same clock.
`timescale 1ns/1ps

module flipc_core_model (
  input  wire logic clk_in,     // System clock
  input  wire logic rst_in,     // Sync reset, high
  input  wire logic irq_req_in, // Request from controller
  input  wire logic auto_in,    // Vector on every request
  input  wire logic ret_cmd_in, // Handler finished
  output logic      take_out,   // Vector call pulse
  output logic      reti_out    // Return pulse
);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      take_out <= 1'b0;
      reti_out <= 1'b0;
    end else begin
      take_out <= auto_in && irq_req_in && !take_out;
      // A plain return would leave the level busy and starve later work.
      reti_out <= ret_cmd_in;
    end
  end
endmodule

/* flipc_chk.sv */
// Port checks of the interrupt priority controller.
// Assumes it is bound to flipc_ctrl with the constants header on the path.
`timescale 1ns/1ps
`include "flipc_params.svh"

module flipc_chk
  import flipc_pkg::*;
(
  input wire logic        clk_in,                // Clock
  input wire logic        rst_in,                // Reset
  input wire logic        global_irq_enable_in,  // Global enable
  input wire logic [17:0] enable_in,             // Source enables
  input wire logic [17:0] priority_high_bits_in, // Level high
  input wire logic [17:0] priority_low_bits_in,  // Level low
  input wire logic        sw_wr_in,              // Flag write
  input wire logic        ext0_pin_in,           // Pin 0
  input wire logic [1:0]  ext_edge_mode_in,      // Edge modes
  input wire logic        take_in,               // Vector call
  input wire logic        reti_in,               // Return
  input wire logic        irq_req_out,           // Request
  input wire logic [15:0] irq_vector_out,        // Vector
  input wire flipc_idx_t  irq_source_out,        // Source
  input wire flipc_lvl_t  irq_level_out,         // Level
  input wire logic        wake_out,              // Wake
  input wire logic [17:0] flags_out,             // Flags
  input wire logic [3:0]  svc_level_out          // In service
);
  localparam logic [15:0] VTAB [18] = '{16'h0003, 16'h0043, 16'h0053,
    16'h000b, 16'h0033, 16'h005b, 16'h0013, 16'h003b, 16'h001b, 16'h0023,
    16'h0073, 16'h004b, 16'h002b, 16'h0063, 16'h006b, 16'h007b, 16'h0083,
    16'h008b};
  logic [17:0] en_q, hi_q, lo_q;
  logic [3:0]  svc_pop;

  // Settings seen by the arbiter when the present request was registered.
  always_ff @(posedge clk_in) begin
    en_q <= enable_in;
    hi_q <= priority_high_bits_in;
    lo_q <= priority_low_bits_in;
  end

  always_comb begin
    svc_pop = svc_level_out[3] ? (svc_level_out & 4'h7) :
              svc_level_out[2] ? (svc_level_out & 4'h3) :
              svc_level_out[1] ? (svc_level_out & 4'h1) : 4'h0;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_enable_gate: assert property (
    irq_req_out |-> en_q[irq_source_out]) else $error("disabled source");
  a_global_block: assert property (
    !global_irq_enable_in |=> !irq_req_out) else $error("global mask");
  a_pending_serve: assert property (
    global_irq_enable_in && |(flags_out & enable_in) && !take_in &&
    !reti_in && svc_level_out == 4'h0 |=> irq_req_out)
    else $error("pending flag not presented");
  a_level_pair: assert property (
    irq_req_out |-> irq_level_out ==
    {hi_q[irq_source_out], lo_q[irq_source_out]}) else $error("level");
  a_preempt_higher: assert property (
    irq_req_out |-> (svc_level_out >> irq_level_out) == 4'h0)
    else $error("preemption at equal or lower level");
  a_take_service: assert property (
    take_in && irq_req_out |=> !irq_req_out &&
    svc_level_out[$past(irq_level_out)]) else $error("take");
  a_reti_pop: assert property (
    reti_in && !take_in |=> !irq_req_out && svc_level_out == $past(svc_pop))
    else $error("return pop");
  a_vector_map: assert property (
    irq_req_out |-> irq_vector_out == VTAB[irq_source_out])
    else $error("vector");
  a_wake_raise: assert property (
    |(flags_out & enable_in & `FLIPC_WAKE_MASK) |=> wake_out)
    else $error("wake missing");
  a_wake_only: assert property (
    wake_out |-> $past(|(enable_in & `FLIPC_WAKE_MASK)))
    else $error("wake from non-wake source");
  a_ext_level: assert property (
    !ext_edge_mode_in[0] |=> flags_out[0] == !$past(ext0_pin_in))
    else $error("level flag");
  a_timer2_kept: assert property (
    take_in && irq_req_out && irq_source_out == `FLIPC_SRC_TMR2 &&
    !sw_wr_in |=> flags_out[12]) else $error("timer2 flag cleared");

  c_take: cover property (take_in && irq_req_out);
  c_nested: cover property (svc_level_out == 4'h6);
  c_wake_masked: cover property (wake_out && !global_irq_enable_in);
endmodule

/* testbench.sv */
// Self-checking bench of the interrupt priority controller.
// Assumes the core model and checker are compiled before this file.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  err_total++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module testbench;
  import flipc_pkg::*;
  logic        clk_in, rst_in, global_irq_enable_in, sw_wr_in, sw_data_in;
  logic        ext0_pin_in, ext1_pin_in, pin_wr_in, take_in, reti_in;
  logic        irq_req_out, wake_out, auto, ret_cmd;
  logic [17:0] enable_in, priority_high_bits_in, priority_low_bits_in;
  logic [17:0] hw_set_in, flags_out;
  logic [1:0]  ext_edge_mode_in, twowire_flags_in, serial0_flags_in;
  logic [1:0]  serial1_flags_in;
  logic [2:0]  serial_periph_flags_in, capture_flags_in;
  logic [7:0]  pin_level_mode_in, pin_state_in, pin_set_in;
  logic [7:0]  pin_wr_data_in, pin_flags_out;
  logic [15:0] irq_vector_out;
  logic [3:0]  svc_level_out;
  flipc_idx_t  sw_idx_in, irq_source_out;
  flipc_lvl_t  irq_level_out;
  int          err_total, check_count;
  logic [15:0] vtab [18] = '{16'h0003, 16'h0043, 16'h0053, 16'h000b,
    16'h0033, 16'h005b, 16'h0013, 16'h003b, 16'h001b, 16'h0023, 16'h0073,
    16'h004b, 16'h002b, 16'h0063, 16'h006b, 16'h007b, 16'h0083, 16'h008b};

  flipc_ctrl flipc_ctrl_i (.clk_in, .rst_in, .global_irq_enable_in,
    .enable_in, .priority_high_bits_in, .priority_low_bits_in, .hw_set_in,
    .sw_wr_in, .sw_idx_in, .sw_data_in, .ext0_pin_in, .ext1_pin_in,
    .ext_edge_mode_in, .pin_level_mode_in, .pin_state_in, .pin_set_in,
    .pin_wr_in, .pin_wr_data_in, .twowire_flags_in, .serial0_flags_in,
    .serial_periph_flags_in, .capture_flags_in, .serial1_flags_in,
    .take_in, .reti_in, .irq_req_out, .irq_vector_out, .irq_source_out,
    .irq_level_out, .wake_out, .flags_out, .pin_flags_out, .svc_level_out);
  flipc_core_model flipc_core_model_i (.clk_in, .rst_in,
    .irq_req_in(irq_req_out), .auto_in(auto), .ret_cmd_in(ret_cmd),
    .take_out(take_in), .reti_out(reti_in));

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic sw(input int i, input logic d);
    cyc(1);
    sw_idx_in = flipc_idx_t'(i);
    sw_data_in = d;
    sw_wr_in = 1'b1;
    cyc(1);
    sw_wr_in = 1'b0;
  endtask
  task automatic ret();
    cyc(1);
    ret_cmd = 1'b1;
    cyc(1);
    ret_cmd = 1'b0;
  endtask
  task automatic pin_write(input logic [7:0] d);
    pin_wr_data_in = d;
    pin_wr_in = 1'b1;
    cyc(1);
    pin_wr_in = 1'b0;
  endtask
  task automatic src_is(input flipc_idx_t s);
    cyc(3);
    `CHK("or source", s, irq_source_out)
  endtask

  task automatic t_vectors();
    for (int i = 0; i < 18; i++) begin
      sw(i, 1'b1);
      cyc(2);
      `CHK("source", flipc_idx_t'(i), irq_source_out)
      `CHK("vector", vtab[i], irq_vector_out)
      `CHK("raised req", 1'b1, irq_req_out)
      sw(i, 1'b0);
      cyc(2);
      `CHK("cleared req", 1'b0, irq_req_out)
    end
    $display("test vectors finished");
  endtask

  task automatic t_tie();
    hw_set_in = 18'h10008;
    cyc(1);
    hw_set_in = 18'h00000;
    cyc(2);
    `CHK("tie source", 5'h03, irq_source_out)
    priority_high_bits_in[16] = 1'b1;
    priority_low_bits_in[16] = 1'b1;
    cyc(2);
    `CHK("level winner", 5'h10, irq_source_out)
    `CHK("level", 2'h3, irq_level_out)
    priority_high_bits_in = 18'h0;
    priority_low_bits_in = 18'h0;
    sw(3, 1'b0);
    sw(16, 1'b0);
    $display("test tie finished");
  endtask

  task automatic t_mask();
    global_irq_enable_in = 1'b0;
    sw(5, 1'b1);
    cyc(3);
    `CHK("masked req", 1'b0, irq_req_out)
    global_irq_enable_in = 1'b1;
    cyc(2);
    `CHK("pending req", 1'b1, irq_req_out)
    enable_in[5] = 1'b0;
    cyc(2);
    `CHK("disabled req", 1'b0, irq_req_out)
    enable_in[5] = 1'b1;
    sw(5, 1'b0);
    $display("test mask finished");
  endtask

  task automatic t_nest();
    priority_low_bits_in = 18'h00028;
    priority_high_bits_in = 18'h00002;
    auto = 1'b1;
    sw(5, 1'b1);
    cyc(4);
    `CHK("svc first", 4'h2, svc_level_out)
    sw(3, 1'b1);
    cyc(3);
    `CHK("equal level", 1'b0, irq_req_out)
    sw(1, 1'b1);
    cyc(4);
    `CHK("svc nested", 4'h6, svc_level_out)
    sw(1, 1'b0);
    sw(5, 1'b0);
    ret();
    cyc(3);
    `CHK("svc resumed", 4'h2, svc_level_out)
    ret();
    cyc(6);
    `CHK("svc waiting", 4'h2, svc_level_out)
    `CHK("timer0 flag", 1'b0, flags_out[3])
    sw(12, 1'b1);
    ret();
    cyc(6);
    `CHK("timer2 flag", 1'b1, flags_out[12])
    auto = 1'b0;
    sw(12, 1'b0);
    ret();
    cyc(3);
    `CHK("svc base", 4'h0, svc_level_out)
    priority_low_bits_in = 18'h0;
    priority_high_bits_in = 18'h0;
    $display("test nest finished");
  endtask

  task automatic t_wake();
    global_irq_enable_in = 1'b0;
    sw(17, 1'b1);
    cyc(2);
    `CHK("wake timer", 1'b1, wake_out)
    sw(17, 1'b0);
    sw(14, 1'b1);
    cyc(2);
    `CHK("wake pwm", 1'b0, wake_out)
    sw(14, 1'b0);
    global_irq_enable_in = 1'b1;
    $display("test wake finished");
  endtask

  task automatic t_ext();
    ext_edge_mode_in[0] = 1'b0;
    ext0_pin_in = 1'b0;
    cyc(2);
    sw(0, 1'b0);
    `CHK("level flag", 1'b1, flags_out[0])
    ext0_pin_in = 1'b1;
    ext_edge_mode_in[0] = 1'b1;
    sw(0, 1'b0);
    `CHK("edge idle", 1'b0, flags_out[0])
    cyc(2);
    auto = 1'b1;
    ext0_pin_in = 1'b0;
    cyc(6);
    `CHK("edge taken", 4'h1, svc_level_out)
    `CHK("edge flag", 1'b0, flags_out[0])
    auto = 1'b0;
    ext0_pin_in = 1'b1;
    ret();
    cyc(3);
    $display("test ext finished");
  endtask

  task automatic t_or();
    twowire_flags_in = 2'b10;
    src_is(5'h04);
    twowire_flags_in = 2'b00;
    serial0_flags_in = 2'b01;
    src_is(5'h09);
    serial0_flags_in = 2'b00;
    serial_periph_flags_in = 3'b100;
    src_is(5'h0b);
    serial_periph_flags_in = 3'b000;
    capture_flags_in = 3'b010;
    src_is(5'h0d);
    capture_flags_in = 3'b000;
    serial1_flags_in = 2'b10;
    src_is(5'h0f);
    serial1_flags_in = 2'b00;
    pin_write(8'h01);
    src_is(5'h07);
    pin_write(8'h00);
    pin_level_mode_in = 8'h04;
    pin_state_in = 8'h04;
    cyc(2);
    pin_set_in = 8'h02;
    pin_write(8'h00);
    pin_set_in = 8'h00;
    cyc(1);
    `CHK("level chan", 8'h06, pin_flags_out)
    pin_state_in = 8'h00;
    cyc(2);
    `CHK("chan off", 8'h02, pin_flags_out)
    $display("test or finished");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Runs of all tests take well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge clk_in);
    err_total++;
    end_of_test();
  end

  initial begin
    {rst_in, global_irq_enable_in, ext0_pin_in, ext1_pin_in} = 4'hf;
    {sw_wr_in, sw_data_in, pin_wr_in, auto, ret_cmd} = 5'h00;
    enable_in = 18'h3ffff;
    {priority_high_bits_in, priority_low_bits_in, hw_set_in} = '0;
    ext_edge_mode_in = 2'b11;
    sw_idx_in = 5'h00;
    {twowire_flags_in, serial0_flags_in, serial1_flags_in} = 6'h00;
    {serial_periph_flags_in, capture_flags_in} = 6'h00;
    {pin_level_mode_in, pin_state_in, pin_set_in} = 24'h000000;
    pin_wr_data_in = 8'h00;
    err_total = 0;
    check_count = 0;
    repeat (20) @(posedge clk_in);
    cyc(1);
    rst_in = 1'b0;
    cyc(1);
    `CHK("reset flags", 18'h0, flags_out)
    t_vectors();
    t_tie();
    t_mask();
    t_nest();
    t_wake();
    t_ext();
    t_or();
    end_of_test();
  end
endmodule

bind flipc_ctrl flipc_chk flipc_chk_i (.clk_in, .rst_in,
  .global_irq_enable_in, .enable_in, .priority_high_bits_in,
  .priority_low_bits_in, .sw_wr_in, .ext0_pin_in, .ext_edge_mode_in,
  .take_in, .reti_in, .irq_req_out, .irq_vector_out, .irq_source_out,
  .irq_level_out, .wake_out, .flags_out, .svc_level_out);
